// ### core/fbps_pkg.sv
// Constants and types for the flash bypass program and status block
package fbps_pkg;
    // Avalon word offsets
    localparam logic [2:0] REG_CMD_ADDR = 3'h0;
    localparam logic [2:0] REG_CMD_DATA = 3'h1;
    localparam logic [2:0] REG_ARRAY    = 3'h2;
    localparam logic [2:0] REG_CTRL     = 3'h3;
    localparam logic [2:0] REG_STATE    = 3'h4;
    // Control register fields
    localparam int CTRL_PROTECT = 0;
    localparam int CTRL_OVERRUN = 1;
    // Command words and unlock addresses
    localparam logic [15:0] CMD_UNLOCK1  = 16'h00aa;
    localparam logic [15:0] CMD_UNLOCK2  = 16'h0055;
    localparam logic [15:0] CMD_BYPASS   = 16'h0020;
    localparam logic [15:0] CMD_PROGRAM  = 16'h00a0;
    localparam logic [15:0] CMD_ERASE    = 16'h0080;
    localparam logic [15:0] CMD_CHIP_ERS = 16'h0010;
    localparam logic [15:0] CMD_SECT_ERS = 16'h0030;
    localparam logic [15:0] CMD_EXIT1    = 16'h0090;
    localparam logic [15:0] CMD_EXIT2    = 16'h0000;
    localparam logic [15:0] CMD_RESET    = 16'h00f0;
    localparam logic [15:0] ADDR_555     = 16'h0555;
    localparam logic [15:0] ADDR_2AA     = 16'h02aa;
    localparam logic [15:0] ERASED_WORD  = 16'hffff;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    // Timing
    localparam int CLK_NS        = 40;
    localparam int PROG_TIME_NS  = 2000;
    localparam int ERASE_TIME_NS = 8000;
    localparam int PROT_PROG_NS  = 1000;
    localparam int PROT_ERASE_NS = 1200;
    localparam logic [15:0] PROG_CYC  = 16'(PROG_TIME_NS / CLK_NS);
    localparam logic [15:0] ERASE_CYC = 16'(ERASE_TIME_NS / CLK_NS);
    localparam logic [15:0] PPOLL_CYC = 16'(PROT_PROG_NS / CLK_NS);
    localparam logic [15:0] EPOLL_CYC = 16'(PROT_ERASE_NS / CLK_NS);

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } fbps_cycle_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_U1   = 3'b001,
        SEQ_U2   = 3'b011,
        SEQ_PROG = 3'b010,
        SEQ_E1   = 3'b110,
        SEQ_E2   = 3'b111,
        SEQ_E3   = 3'b101,
        SEQ_EX1  = 3'b100
    } fbps_seq_t;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_RUN  = 2'b01,
        OP_FAIL = 2'b11,
        OP_PROT = 2'b10
    } fbps_op_t;
endpackage : fbps_pkg

// ### core/fbps_core.sv
// Flash command decode, bypass mode and polarity-poll status over Avalon-MM
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module fbps_core
    import fbps_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Accelerate supply level detect pin
    input  wire logic        accel_supply_input,
    // Avalon-MM slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Status pins
    output logic             busy,
    output logic             bypass_active
);
    logic        rst_s1_reg, rst_s2_reg;
    logic        acc_s1_reg, acc_s2_reg, acc_d_reg;
    logic        wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [15:0] addr_reg, addr_next;
    logic [15:0] last_reg, last_next;
    logic [1:0]  ctrl_reg, ctrl_next;
    fbps_seq_t   seq_reg, seq_next;
    fbps_op_t    op_reg, op_next;
    logic        bypass_reg, bypass_next;
    logic        erase_reg, erase_next;
    logic        tog_reg, tog_next;
    logic        done_reg, done_next;
    logic [15:0] timer_reg, timer_next;
    fbps_cycle_t prog_reg, prog_next;
    logic [15:0] array_reg, array_next;
    logic [6:0]  stale_reg, stale_next;
    logic        busy_reg, busy_next;
    fbps_cycle_t cyc;
    logic        take, cmd_we, rd_take;
    logic [15:0] status;

    // Reset release through two flops; async assert only
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    assign take    = wait_reg && (avs_read || avs_write);
    assign cmd_we  = take && avs_write && avs_address == REG_CMD_DATA;
    assign rd_take = take && avs_read && avs_address == REG_ARRAY;
    assign cyc     = '{addr: addr_reg, data: avs_writedata[15:0]};
    // Polarity bit, toggle, time limit, sector toggle on erase
    assign status = {8'h00,
                     erase_reg ? 1'b0 : ~prog_reg.data[7],
                     tog_reg, op_reg == OP_FAIL, 2'b00,
                     erase_reg & tog_reg, 2'b00};

    always_comb
    begin
        wait_next   = 1'b1;
        rdata_next  = rdata_reg;
        addr_next   = addr_reg;
        last_next   = last_reg;
        ctrl_next   = ctrl_reg;
        seq_next    = seq_reg;
        op_next     = op_reg;
        bypass_next = bypass_reg;
        erase_next  = erase_reg;
        tog_next    = tog_reg;
        done_next   = done_reg;
        timer_next  = timer_reg;
        prog_next   = prog_reg;
        array_next  = array_reg;
        stale_next  = stale_reg;
        // Entry on the rising edge only, so exit still works with it high
        if (acc_s2_reg && !acc_d_reg && op_reg == OP_IDLE)
            bypass_next = 1'b1;
        // Embedded operation timing
        if (op_reg != OP_IDLE && op_reg != OP_FAIL && timer_reg != 16'h0000)
            timer_next = timer_reg - 16'h0001;
        if (op_reg == OP_PROT && timer_reg == 16'h0000)
            op_next = OP_IDLE;
        if (op_reg == OP_RUN && timer_reg == 16'h0000)
        begin
            if (ctrl_reg[CTRL_OVERRUN])
                op_next = OP_FAIL;
            else
            begin
                op_next   = OP_IDLE;
                done_next = 1'b1;
                // Ones cannot be written over zeros; poll went wrong
                array_next = erase_reg ? ERASED_WORD
                           : (array_reg & prog_reg.data);
            end
        end
        if (take)
        begin
            wait_next = 1'b0;
            rdata_next = 32'h0000_0000;
            case (avs_address)
                REG_CMD_ADDR: rdata_next[15:0] = addr_reg;
                REG_CMD_DATA: rdata_next[15:0] = last_reg;
                REG_CTRL:     rdata_next[1:0]  = ctrl_reg;
                REG_STATE:    rdata_next[3:0]  = {acc_s2_reg,
                                  op_reg == OP_FAIL, busy_reg, bypass_reg};
                REG_ARRAY:
                begin
                    if (op_reg != OP_IDLE)
                    begin
                        rdata_next[15:0] = status;
                        tog_next = ~tog_reg;
                        stale_next = status[6:0];
                    end
                    else if (done_reg)
                    begin
                        // First read after completion: only bits 15 to 7 true
                        rdata_next[15:0] = {array_reg[15:7], stale_reg};
                        done_next = 1'b0;
                    end
                    else
                        rdata_next[15:0] = array_reg;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
            if (avs_write && avs_address == REG_CMD_ADDR)
                addr_next = avs_writedata[15:0];
            if (avs_write && avs_address == REG_CTRL)
                ctrl_next = avs_writedata[1:0];
        end
        if (cmd_we)
        begin
            last_next = cyc.data;
            seq_next  = SEQ_IDLE;
            if (op_reg == OP_FAIL && cyc.data == CMD_RESET)
                op_next = OP_IDLE;
            else if (op_reg == OP_IDLE)
            begin
                case (seq_reg)
                    SEQ_IDLE:
                        if (bypass_reg)
                        begin
                            // Anything else is dropped, mode kept
                            if (cyc.data == CMD_PROGRAM)
                                seq_next = SEQ_PROG;
                            else if (cyc.data == CMD_ERASE)
                                seq_next = SEQ_E1;
                            else if (cyc.data == CMD_EXIT1)
                                seq_next = SEQ_EX1;
                        end
                        else if (cyc.data == CMD_UNLOCK1
                                 && cyc.addr == ADDR_555)
                            seq_next = SEQ_U1;
                    SEQ_U1:
                        if (cyc.data == CMD_UNLOCK2 && cyc.addr == ADDR_2AA)
                            seq_next = SEQ_U2;
                    SEQ_U2:
                        if (cyc.addr == ADDR_555)
                        begin
                            if (cyc.data == CMD_BYPASS)
                                bypass_next = 1'b1;
                            else if (cyc.data == CMD_PROGRAM)
                                seq_next = SEQ_PROG;
                            else if (cyc.data == CMD_ERASE)
                                seq_next = SEQ_E1;
                        end
                    SEQ_PROG:
                    begin
                        // Status is live from this write on
                        prog_next  = cyc;
                        erase_next = 1'b0;
                        op_next    = ctrl_reg[CTRL_PROTECT] ? OP_PROT : OP_RUN;
                        timer_next = ctrl_reg[CTRL_PROTECT] ? PPOLL_CYC
                                                            : PROG_CYC;
                    end
                    SEQ_E1:
                        if (cyc.data == CMD_UNLOCK1 && cyc.addr == ADDR_555)
                            seq_next = SEQ_E2;
                    SEQ_E2:
                        if (cyc.data == CMD_UNLOCK2 && cyc.addr == ADDR_2AA)
                            seq_next = SEQ_E3;
                    SEQ_E3:
                        if ((cyc.data == CMD_CHIP_ERS && cyc.addr == ADDR_555)
                            || cyc.data == CMD_SECT_ERS)
                        begin
                            erase_next = 1'b1;
                            op_next    = ctrl_reg[CTRL_PROTECT] ? OP_PROT
                                                                : OP_RUN;
                            timer_next = ctrl_reg[CTRL_PROTECT] ? EPOLL_CYC
                                                                : ERASE_CYC;
                        end
                    SEQ_EX1:
                        if (cyc.data == CMD_EXIT2)
                            bypass_next = 1'b0;
                    default: seq_next = SEQ_IDLE;
                endcase
            end
        end
        busy_next = op_next != OP_IDLE;
    end

    always_ff @(posedge mclk or negedge rst_s2_reg)
    begin
        if (!rst_s2_reg)
        begin
            acc_s1_reg <= 1'b0;
            acc_s2_reg <= 1'b0;
            acc_d_reg  <= 1'b0;
            wait_reg   <= 1'b1;
            rdata_reg  <= 32'h0000_0000;
            addr_reg   <= RESET_WORD;
            last_reg   <= RESET_WORD;
            ctrl_reg   <= 2'h0;
            seq_reg    <= SEQ_IDLE;
            op_reg     <= OP_IDLE;
            bypass_reg <= 1'b0;
            erase_reg  <= 1'b0;
            tog_reg    <= 1'b0;
            done_reg   <= 1'b0;
            timer_reg  <= 16'h0000;
            prog_reg   <= '0;
            array_reg  <= ERASED_WORD;
            stale_reg  <= 7'h00;
            busy_reg   <= 1'b0;
        end
        else
        begin
            acc_s1_reg <= accel_supply_input;
            acc_s2_reg <= acc_s1_reg;
            acc_d_reg  <= acc_s2_reg;
            wait_reg   <= wait_next;
            rdata_reg  <= rdata_next;
            addr_reg   <= addr_next;
            last_reg   <= last_next;
            ctrl_reg   <= ctrl_next;
            seq_reg    <= seq_next;
            op_reg     <= op_next;
            bypass_reg <= bypass_next;
            erase_reg  <= erase_next;
            tog_reg    <= tog_next;
            done_reg   <= done_next;
            timer_reg  <= timer_next;
            prog_reg   <= prog_next;
            array_reg  <= array_next;
            stale_reg  <= stale_next;
            busy_reg   <= busy_next;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign busy            = busy_reg;
    assign bypass_active   = bypass_reg;

    a_bypass_entry: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        cmd_we && op_reg == OP_IDLE && seq_reg == SEQ_U2
        && cyc.addr == ADDR_555 && cyc.data == CMD_BYPASS
        |=> bypass_reg && seq_reg == SEQ_IDLE)
        else $error("bypass not entered");
    a_prog_start: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        cmd_we && op_reg == OP_IDLE && seq_reg == SEQ_PROG
        |=> busy_reg && prog_reg.data == $past(avs_writedata[15:0]))
        else $error("program did not start");
    a_erase_short: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        cmd_we && op_reg == OP_IDLE && bypass_reg && seq_reg == SEQ_IDLE
        && cyc.data == CMD_ERASE |=> seq_reg == SEQ_E1)
        else $error("short erase not taken");
    a_bypass_hold: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        cmd_we && op_reg == OP_IDLE && bypass_reg && seq_reg == SEQ_IDLE
        && cyc.data != CMD_PROGRAM && cyc.data != CMD_ERASE
        && cyc.data != CMD_EXIT1 |=> bypass_reg && seq_reg == SEQ_IDLE)
        else $error("stray write changed bypass");
    a_bypass_exit: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        cmd_we && op_reg == OP_IDLE && seq_reg == SEQ_EX1
        && cyc.data == CMD_EXIT2 |=> !bypass_active)
        else $error("bypass not left");
    a_accel_entry: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        acc_s2_reg && !acc_d_reg && op_reg == OP_IDLE |=> bypass_reg)
        else $error("accelerate did not force bypass");
    a_prog_poll: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        rd_take && op_reg == OP_RUN && !erase_reg
        |=> avs_readdata[7] != prog_reg.data[7])
        else $error("program poll bit wrong");
    a_erase_poll: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        rd_take && op_reg != OP_IDLE && erase_reg |=> !avs_readdata[7])
        else $error("erase poll bit not zero");
    a_toggle_flip: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        rd_take && op_reg == OP_RUN
        |=> avs_readdata[6] != tog_reg && avs_waitrequest == 1'b0)
        else $error("toggle bit did not invert");
    a_prot_return: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        op_reg == OP_PROT && timer_reg == 16'h0000
        |=> op_reg == OP_IDLE && $stable(array_reg))
        else $error("protected op wrote or stuck");
    a_limit_bit: assert property (@(posedge mclk) disable iff (!rst_s2_reg)
        rd_take && op_reg == OP_FAIL |=> avs_readdata[5])
        else $error("time limit bit missing");
endmodule : fbps_core

// ### bench/fbps_host.sv
// Host memory controller model issuing flash command cycles over Avalon-MM
`timescale 1ns/1ps
module fbps_host
    import fbps_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Avalon-MM master
    output logic      [2:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    logic        wait_seen;
    logic [15:0] data_seen;

    initial
    begin
        avs_address   = 3'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
    end

    // Taken mid-cycle so the value used at the next edge is race free
    always @(negedge mclk)
    begin
        wait_seen <= avs_waitrequest;
        data_seen <= avs_readdata[15:0];
    end

    task automatic xfer(input logic rd, input logic [2:0] a,
                        input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        avs_address   <= a;
        avs_read      <= rd;
        avs_write     <= ~rd;
        avs_writedata <= {16'h0, d};
        do @(posedge mclk); while (wait_seen !== 1'b0);
        q = data_seen;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer

    task automatic cmd(input logic [15:0] fa, input logic [15:0] fd);
        logic [15:0] q;
        xfer(1'b0, REG_CMD_ADDR, fa, q);
        xfer(1'b0, REG_CMD_DATA, fd, q);
    endtask : cmd

    task automatic unlock_entry();
        cmd(ADDR_555, CMD_UNLOCK1);
        cmd(ADDR_2AA, CMD_UNLOCK2);
        cmd(ADDR_555, CMD_BYPASS);
    endtask : unlock_entry

    task automatic bp_program(input logic [15:0] fa, input logic [15:0] fd);
        cmd(16'h0123, CMD_PROGRAM);
        cmd(fa, fd);
    endtask : bp_program

    task automatic bp_erase(input logic chip);
        cmd(ADDR_555, CMD_ERASE);
        cmd(ADDR_555, CMD_UNLOCK1);
        cmd(ADDR_2AA, CMD_UNLOCK2);
        cmd(ADDR_555, chip ? CMD_CHIP_ERS : CMD_SECT_ERS);
    endtask : bp_erase

    task automatic bp_exit();
        cmd(16'h0000, CMD_EXIT1);
        cmd(16'h0abc, CMD_EXIT2);
    endtask : bp_exit

    // The array register is a single word, so the poll needs no command address
    task automatic poll(output logic [15:0] q);
        xfer(1'b1, REG_ARRAY, 16'h0, q);
    endtask : poll
endmodule : fbps_host

// ### bench/tb_flash_bypass_program_status.sv
// Self-checking testbench for the flash bypass program and status block
`timescale 1ns/1ps
module tb_flash_bypass_program_status;
    import fbps_pkg::*;
    logic        mclk, rst_b, accel_supply_input, busy, bypass_active;
    logic [2:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] a, b;
    int          errors, n_checks, cycles;

    fbps_core dut (.mclk(mclk), .rst_b(rst_b),
        .accel_supply_input(accel_supply_input), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .busy(busy),
        .bypass_active(bypass_active));
    fbps_host host (.mclk(mclk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    always #20 mclk = ~mclk;

    task automatic chk(input string what, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    // Waits out an embedded op, then reads twice: the first may be mixed
    task automatic settle(input logic [15:0] e);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        chk("busy", 16'h0, {15'h0, busy});
        host.poll(a);
        host.poll(b);
        chk("array", e, b);
    endtask : settle

    task automatic t_entry();
        host.unlock_entry();
        host.xfer(1'b1, REG_STATE, 16'h0, a);
        chk("state bypass", 16'h1, a);
        host.xfer(1'b1, REG_CMD_DATA, 16'h0, a);
        chk("last command", CMD_BYPASS, a);
        host.xfer(1'b1, 3'h5, 16'h0, a);
        chk("unmapped", 16'h0, a);
        $display("test entry done");
    endtask : t_entry

    task automatic t_program();
        host.bp_program(16'h0400, 16'h007f);
        host.poll(a);
        host.poll(b);
        chk("poll bit", 16'h1, {15'h0, a[7]});
        chk("toggle", 16'h1, {15'h0, a[6] ^ b[6]});
        chk("abort bit", 16'h0, {15'h0, a[1]});
        settle(16'h007f);
        chk("bypass kept", 16'h1, {15'h0, bypass_active});
        $display("test program done");
    endtask : t_program

    task automatic t_ignored();
        host.cmd(16'h0300, 16'h0077);
        host.cmd(ADDR_2AA, CMD_UNLOCK2);
        chk("busy idle", 16'h0, {15'h0, busy});
        chk("bypass kept", 16'h1, {15'h0, bypass_active});
        settle(16'h007f);
        $display("test ignored done");
    endtask : t_ignored

    task automatic t_protect();
        host.xfer(1'b0, REG_CTRL, 16'h0001, a);
        host.xfer(1'b1, REG_CTRL, 16'h0000, a);
        chk("control", 16'h1, a);
        host.bp_program(16'h0400, 16'h0000);
        host.poll(a);
        chk("prot poll", 16'h1, {15'h0, a[7]});
        settle(16'h007f);
        host.bp_erase(1'b0);
        host.poll(a);
        chk("prot erase poll", 16'h0, {15'h0, a[7]});
        settle(16'h007f);
        host.xfer(1'b0, REG_CTRL, 16'h0000, a);
        $display("test protect done");
    endtask : t_protect

    task automatic t_erase();
        for (int k = 0; k < 2; k++)
        begin
            host.bp_program(16'h0400, 16'h1234);
            // Second pass programs over an erased word
            settle(k == 0 ? 16'h0034 : 16'h1234);
            host.bp_erase(k[0]);
            host.poll(a);
            host.poll(b);
            chk("erase poll", 16'h0, {15'h0, a[7]});
            chk("erase toggle", 16'h1, {15'h0, a[2] ^ b[2]});
            settle(ERASED_WORD);
        end
        $display("test erase done");
    endtask : t_erase

    task automatic t_overrun();
        host.xfer(1'b0, REG_CTRL, 16'h0002, a);
        host.bp_program(16'h0400, 16'h0080);
        a = 16'h0;
        for (int n = 0; n < 100 && a[5] !== 1'b1; n++)
            host.poll(a);
        chk("time limit", 16'h1, {15'h0, a[5]});
        chk("busy held", 16'h1, {15'h0, busy});
        host.xfer(1'b0, REG_CTRL, 16'h0000, a);
        host.cmd(16'h0000, CMD_RESET);
        host.bp_erase(1'b1);
        settle(ERASED_WORD);
        $display("test overrun done");
    endtask : t_overrun

    task automatic t_exit_accel();
        host.bp_exit();
        chk("bypass left", 16'h0, {15'h0, bypass_active});
        // Plain program path outside bypass, full unlock prefix
        host.cmd(ADDR_555, CMD_UNLOCK1);
        host.cmd(ADDR_2AA, CMD_UNLOCK2);
        host.cmd(ADDR_555, CMD_PROGRAM);
        host.cmd(16'h0400, 16'h0fff);
        settle(16'h0fff);
        chk("normal mode", 16'h0, {15'h0, bypass_active});
        accel_supply_input <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("accel bypass", 16'h1, {15'h0, bypass_active});
        host.bp_program(16'h0400, 16'h0f80);
        host.poll(a);
        chk("accel poll", 16'h0, {15'h0, a[7]});
        settle(16'h0f80);
        host.bp_exit();
        accel_supply_input <= 1'b0;
        chk("accel exit", 16'h0, {15'h0, bypass_active});
        $display("test exit and accel done");
    endtask : t_exit_accel

    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        accel_supply_input = 1'b0;
        errors = 0;
        n_checks = 0;
        cycles = 0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_entry();
        t_program();
        t_ignored();
        t_protect();
        t_erase();
        t_overrun();
        t_exit_accel();
        finish_test();
    end
endmodule : tb_flash_bypass_program_status
